// >>> pushbutton_display_menu.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - power-on shows name, version, then identification code once
// - status messages: delay, ready, remote off, hold, pressure differential
// - short press in normal mode steps to the next variable
// - no press for over two minutes returns display to normal indicator
// - view order suction pressure through slave address, then wrap to normal
// - pressures in kPa, temperatures whole degrees with minus below zero
// - condensing and evaporating temperatures derived from pressures
// - unavailable measurement shows a single dash
// - settings need power-on done, compressor off, no start request
// - two-second hold scans level 1, release selects shown option
// - level 1 offers test, commissioning, fan high, fan low, level 2, normal
// - fan high defaults 2.0 V, fan low 5.0 V
// - in levels 2 to 4 a short press moves to the next option
// - option shown four times without press is selected automatically
// - level 2 offers address 44, valve delay 40 s, three flags, level 3, normal
// - level 3 offers baud 19200, even parity one stop bit, level 4, normal
// - level 4 offers compressor model, valve mode, return to normal
module pushbutton_display_menu #(
    parameter longint view_timeout = menu_pkg::view_timeout_cycles,
    parameter int hold = menu_pkg::hold_cycles,
    parameter int char_period = menu_pkg::char_cycles,
    parameter int intro_period = menu_pkg::intro_cycles,
    parameter int debounce = menu_pkg::debounce_cycles
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic menu_push_button,
    input wire logic startup_delay,
    input wire logic remote_off,
    input wire logic timer_hold,
    input wire logic pressure_too_high,
    input wire logic compressor_on,
    input wire logic start_request,
    input wire logic [13:0] view_valid,
    input wire logic [15:0] suction_pressure,
    input wire logic [15:0] discharge_pressure,
    input wire logic signed [15:0] suction_temp,
    input wire logic signed [15:0] discharge_temp,
    input wire logic signed [15:0] deice_temp,
    input wire logic [7:0] capacity,
    input wire logic [7:0] valve_one_opening,
    input wire logic [7:0] valve_two_opening,
    output logic [5:0] display_code,
    output logic [15:0] display_value,
    output logic display_negative,
    output logic display_dash,
    output logic display_flash,
    output logic [5:0] option_selected,
    output logic option_strobe,
    output logic test_active,
    output logic commissioning,
    output logic [7:0] fan_high_voltage,
    output logic [7:0] fan_low_voltage,
    output logic [7:0] slave_addr,
    output logic [7:0] valve_delay,
    output logic fan_fixed_speed,
    output logic remote_thermostat,
    output logic sat_temp_control,
    output logic [2:0] baud_select,
    output logic [1:0] parity_select,
    output logic compressor_model_req,
    output logic valve_mode_req
);
    menu_pkg::menu_state_t state;
    logic pressed;
    logic short_press;
    logic long_start;
    logic release_evt;
    logic [1:0] intro_step;
    logic [31:0] intro_cnt;
    logic [3:0] view_index;
    logic [39:0] idle_cnt;
    logic [2:0] level;
    logic [3:0] opt;
    logic [31:0] char_cnt;
    logic [2:0] shown;
    logic [3:0] opt_limit;
    logic [5:0] sel_code;
    logic menu_allowed;
    logic [15:0] fmt_mag;
    logic fmt_neg;
    logic fmt_dash;

    button_conditioner #(.debounce(debounce), .hold(hold)) u_button (
        .clk(clk),
        .reset_n(reset_n),
        .button_raw(menu_push_button),
        .pressed(pressed),
        .short_press(short_press),
        .long_start(long_start),
        .release_evt(release_evt)
    );

    value_formatter u_format (
        .clk(clk),
        .reset_n(reset_n),
        .view_index(view_index),
        .view_valid(view_valid),
        .suction_pressure(suction_pressure),
        .discharge_pressure(discharge_pressure),
        .suction_temp(suction_temp),
        .discharge_temp(discharge_temp),
        .deice_temp(deice_temp),
        .capacity(capacity),
        .valve_one_opening(valve_one_opening),
        .valve_two_opening(valve_two_opening),
        .slave_addr(slave_addr),
        .magnitude(fmt_mag),
        .negative(fmt_neg),
        .dash(fmt_dash)
    );

    // option count per level
    always_comb begin
        case (level)
            3'h1: opt_limit = menu_pkg::level1_opts;
            3'h2: opt_limit = menu_pkg::level2_opts;
            3'h3: opt_limit = menu_pkg::level3_opts;
            default: opt_limit = menu_pkg::level4_opts;
        endcase
        sel_code = {level, opt[2:0]};
        menu_allowed = !compressor_on && !start_request;
    end

    // main menu sequencer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= menu_pkg::st_intro;
            intro_step <= 2'h0;
            intro_cnt <= 32'h0;
            view_index <= 4'h0;
            idle_cnt <= 40'h0;
            level <= 3'h1;
            opt <= 4'h0;
            char_cnt <= 32'h0;
            shown <= 3'h0;
            option_selected <= 6'h0;
            option_strobe <= 1'b0;
        end else begin
            option_strobe <= 1'b0;
            case (state)
                menu_pkg::st_intro: begin
                    // three messages, one period each
                    if (intro_cnt == 32'(intro_period - 1)) begin
                        intro_cnt <= 32'h0;
                        intro_step <= intro_step + 2'h1;
                        if (intro_step == 2'h2) begin
                            state <= menu_pkg::st_normal;
                        end
                    end else begin
                        intro_cnt <= intro_cnt + 32'h1;
                    end
                end
                menu_pkg::st_normal: begin
                    if (long_start && menu_allowed) begin
                        state <= menu_pkg::st_l1_scan;
                        level <= 3'h1;
                        opt <= 4'h0;
                        char_cnt <= 32'h0;
                        view_index <= 4'h0;
                    end else if (short_press) begin
                        idle_cnt <= 40'h0;
                        // wrap after the last view
                        view_index <= (view_index == 4'(menu_pkg::view_count - 1)) ?
                            4'h0 : view_index + 4'h1;
                    end else if (view_index != 4'h0) begin
                        if (idle_cnt >= 40'(view_timeout)) begin
                            view_index <= 4'h0;
                            idle_cnt <= 40'h0;
                        end else begin
                            idle_cnt <= idle_cnt + 40'h1;
                        end
                    end else begin
                        idle_cnt <= 40'h0;
                    end
                end
                menu_pkg::st_l1_scan: begin
                    // step options while held
                    if (release_evt) begin
                        option_selected <= sel_code;
                        option_strobe <= 1'b1;
                        state <= menu_pkg::st_action;
                    end else if (char_cnt == 32'(char_period - 1)) begin
                        char_cnt <= 32'h0;
                        opt <= (opt == opt_limit - 4'h1) ? 4'h0 : opt + 4'h1;
                    end else begin
                        char_cnt <= char_cnt + 32'h1;
                    end
                end
                menu_pkg::st_menu: begin
                    if (short_press) begin
                        opt <= (opt == opt_limit - 4'h1) ? 4'h0 : opt + 4'h1;
                        shown <= 3'h0;
                        char_cnt <= 32'h0;
                    end else if (pressed) begin
                        char_cnt <= 32'h0; // press pending, no auto select
                    end else if (char_cnt == 32'(char_period - 1)) begin
                        char_cnt <= 32'h0;
                        if (shown == 3'(menu_pkg::auto_select_count - 1)) begin
                            shown <= 3'h0;
                            option_selected <= sel_code;
                            option_strobe <= 1'b1;
                            state <= menu_pkg::st_action;
                        end else begin
                            shown <= shown + 3'h1;
                        end
                    end else begin
                        char_cnt <= char_cnt + 32'h1;
                    end
                end
                menu_pkg::st_action: begin
                    // advance one level or return to normal
                    char_cnt <= 32'h0;
                    shown <= 3'h0;
                    if (opt == opt_limit - 4'h2) begin
                        level <= level + 3'h1;
                        opt <= 4'h0;
                        state <= menu_pkg::st_menu;
                    end else begin
                        opt <= 4'h0;
                        state <= menu_pkg::st_normal;
                    end
                end
                default: state <= menu_pkg::st_normal;
            endcase
        end
    end

    // settings from selected options
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            test_active <= 1'b0;
            commissioning <= 1'b0;
            fan_high_voltage <= menu_pkg::fan_high_default;
            fan_low_voltage <= menu_pkg::fan_low_default;
            slave_addr <= menu_pkg::slave_addr_default;
            valve_delay <= menu_pkg::valve_delay_default;
            fan_fixed_speed <= 1'b0;
            remote_thermostat <= 1'b0;
            sat_temp_control <= 1'b0;
            baud_select <= menu_pkg::baud_default;
            parity_select <= menu_pkg::parity_default;
            compressor_model_req <= 1'b0;
            valve_mode_req <= 1'b0;
        end else begin
            compressor_model_req <= 1'b0;
            valve_mode_req <= 1'b0;
            if (option_strobe) begin
                case (option_selected)
                    6'h08: test_active <= 1'b1;
                    6'h09: commissioning <= !commissioning;
                    6'h0a: fan_high_voltage <= fan_high_voltage + 8'h1;
                    6'h0b: fan_low_voltage <= fan_low_voltage + 8'h1;
                    6'h10: slave_addr <= slave_addr + 8'h1;
                    6'h11: valve_delay <= valve_delay + 8'h1;
                    6'h12: fan_fixed_speed <= !fan_fixed_speed;
                    6'h13: remote_thermostat <= !remote_thermostat;
                    6'h14: sat_temp_control <= !sat_temp_control;
                    6'h18: baud_select <= baud_select + 3'h1;
                    6'h19: parity_select <= parity_select + 2'h1;
                    6'h20: compressor_model_req <= 1'b1;
                    6'h21: valve_mode_req <= 1'b1;
                    default: test_active <= test_active;
                endcase
            end
        end
    end

    // display source by priority
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            display_code <= menu_pkg::disp_name;
            display_value <= 16'h0;
            display_negative <= 1'b0;
            display_dash <= 1'b0;
            display_flash <= 1'b0;
        end else begin
            display_value <= 16'h0;
            display_negative <= 1'b0;
            display_dash <= 1'b0;
            display_flash <= 1'b0;
            if (state == menu_pkg::st_intro) begin
                case (intro_step)
                    2'h0: display_code <= menu_pkg::disp_name;
                    2'h1: begin
                        display_code <= menu_pkg::disp_version;
                        display_value <= menu_pkg::version_code;
                    end
                    default: begin
                        display_code <= menu_pkg::disp_ident;
                        display_value <= menu_pkg::ident_code;
                    end
                endcase
            end else if (state != menu_pkg::st_normal) begin
                display_code <= menu_pkg::disp_menu_base | {3'h0, opt[2:0]};
                display_value <= {13'h0, level};
            end else if (view_index != 4'h0) begin
                display_code <= menu_pkg::disp_view_base | {2'h0, view_index};
                display_value <= fmt_mag;
                display_negative <= fmt_neg;
                display_dash <= fmt_dash;
            end else if (startup_delay) begin
                display_code <= menu_pkg::disp_delay;
            end else if (remote_off) begin
                display_code <= menu_pkg::disp_remote_off;
            end else if (pressure_too_high) begin
                display_code <= menu_pkg::pressure_differential_message;
            end else if (timer_hold) begin
                display_code <= menu_pkg::disp_hold;
            end else begin
                display_code <= menu_pkg::disp_ready;
                display_flash <= 1'b1;
            end
        end
    end
endmodule // pushbutton_display_menu
`default_nettype wire

// >>> menu_pkg.sv
package menu_pkg;
    // clock and timing
    localparam int clk_hz = 200_000_000;
    localparam int hold_time_ms = 2000;
    localparam int hold_cycles = (clk_hz / 1000) * hold_time_ms;
    localparam int view_timeout_s = 120;
    localparam longint view_timeout_cycles = longint'(clk_hz) * view_timeout_s;
    localparam int debounce_time_us = 10;
    localparam int debounce_cycles = (clk_hz / 1_000_000) * debounce_time_us;
    localparam int char_time_ms = 500;
    localparam int char_cycles = (clk_hz / 1000) * char_time_ms;
    localparam int auto_select_count = 4;
    localparam int intro_time_ms = 1000;
    localparam int intro_cycles = (clk_hz / 1000) * intro_time_ms;
    // display codes
    localparam logic [5:0] disp_name = 6'h01;
    localparam logic [5:0] disp_version = 6'h02;
    localparam logic [5:0] disp_ident = 6'h03;
    localparam logic [5:0] disp_delay = 6'h04;
    localparam logic [5:0] disp_ready = 6'h05;
    localparam logic [5:0] disp_remote_off = 6'h06;
    localparam logic [5:0] disp_hold = 6'h07;
    localparam logic [5:0] pressure_differential_message = 6'h08;
    localparam logic [5:0] disp_view_base = 6'h10;
    localparam logic [5:0] disp_menu_base = 6'h20;
    localparam int view_count = 14;
    // option counts per level
    localparam logic [3:0] level1_opts = 4'h6;
    localparam logic [3:0] level2_opts = 4'h7;
    localparam logic [3:0] level3_opts = 4'h4;
    localparam logic [3:0] level4_opts = 4'h3;
    // factory defaults
    localparam logic [7:0] fan_high_default = 8'h14; // 2.0 V in tenths
    localparam logic [7:0] fan_low_default = 8'h32;  // 5.0 V in tenths
    localparam logic [7:0] slave_addr_default = 8'h2c; // 44
    localparam logic [7:0] valve_delay_default = 8'h28; // 40 s
    localparam logic [2:0] baud_default = 3'h4;    // 19200 index
    localparam logic [1:0] parity_default = 2'h1;  // even, one stop bit
    localparam logic [15:0] ident_code = 16'h5a5a; // arbitrary value
    localparam logic [15:0] version_code = 16'h0612;
    typedef enum logic [4:0] {
        st_intro = 5'b00001,
        st_normal = 5'b00010,
        st_l1_scan = 5'b00100,
        st_menu = 5'b01000,
        st_action = 5'b10000
    } menu_state_t;
endpackage

// >>> button_conditioner.sv
`timescale 1ns/100ps
`default_nettype none
module button_conditioner #(
    parameter int debounce = menu_pkg::debounce_cycles,
    parameter int hold = menu_pkg::hold_cycles
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic button_raw,
    output logic pressed,
    output logic short_press,
    output logic long_start,
    output logic release_evt
);
    logic sync1;
    logic sync2;
    logic [15:0] bounce_cnt;
    logic [31:0] hold_cnt;

    // two-stage synchroniser
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= button_raw;
            sync2 <= sync1;
        end
    end

    // stable level after debounce window
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bounce_cnt <= 16'h0;
            pressed <= 1'b0;
        end else if (sync2 == pressed) begin
            bounce_cnt <= 16'h0;
        end else if (bounce_cnt == 16'(debounce - 1)) begin
            bounce_cnt <= 16'h0;
            pressed <= sync2;
        end else begin
            bounce_cnt <= bounce_cnt + 16'h1;
        end
    end

    // press duration and classification
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hold_cnt <= 32'h0;
            short_press <= 1'b0;
            long_start <= 1'b0;
            release_evt <= 1'b0;
        end else begin
            short_press <= 1'b0;
            long_start <= 1'b0;
            release_evt <= 1'b0;
            if (pressed) begin
                if (hold_cnt != 32'(hold)) begin
                    hold_cnt <= hold_cnt + 32'h1;
                end
                if (hold_cnt == 32'(hold - 1)) begin
                    long_start <= 1'b1;
                end
            end else if (hold_cnt != 32'h0) begin
                hold_cnt <= 32'h0;
                release_evt <= 1'b1;
                short_press <= (hold_cnt < 32'(hold));
            end
        end
    end
endmodule // button_conditioner
`default_nettype wire

// >>> value_formatter.sv
`timescale 1ns/100ps
`default_nettype none
module value_formatter (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] view_index,
    input wire logic [13:0] view_valid,
    input wire logic [15:0] suction_pressure,
    input wire logic [15:0] discharge_pressure,
    input wire logic signed [15:0] suction_temp,
    input wire logic signed [15:0] discharge_temp,
    input wire logic signed [15:0] deice_temp,
    input wire logic [7:0] capacity,
    input wire logic [7:0] valve_one_opening,
    input wire logic [7:0] valve_two_opening,
    input wire logic [7:0] slave_addr,
    output logic [15:0] magnitude,
    output logic negative,
    output logic dash
);
    logic signed [15:0] evap_t;
    logic signed [15:0] cond_t;
    logic signed [15:0] value;

    // saturation temperature from pressure, kPa to whole degrees
    function automatic logic signed [15:0] sat_temp(input logic [15:0] kpa);
        logic [15:0] scaled;
        scaled = 16'(kpa / 16'd20);
        sat_temp = $signed(scaled) - 16'sd40;
    endfunction

    always_comb begin
        evap_t = sat_temp(suction_pressure);
        cond_t = sat_temp(discharge_pressure);
        case (view_index)
            4'h1: value = $signed(suction_pressure);
            4'h2: value = evap_t;
            4'h3: value = suction_temp;
            4'h4: value = suction_temp - evap_t;
            4'h5: value = $signed(discharge_pressure);
            4'h6: value = cond_t;
            4'h7: value = discharge_temp;
            4'h8: value = discharge_temp - cond_t;
            4'h9: value = deice_temp;
            4'ha: value = $signed({8'h0, capacity});
            4'hb: value = $signed({8'h0, valve_one_opening});
            4'hc: value = $signed({8'h0, valve_two_opening});
            4'hd: value = $signed({8'h0, slave_addr});
            default: value = 16'sh0;
        endcase
    end

    // registered value with sign and dash
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            magnitude <= 16'h0;
            negative <= 1'b0;
            dash <= 1'b0;
        end else begin
            dash <= !view_valid[view_index];
            negative <= value[15] && !(view_index inside {4'h1, 4'h5});
            magnitude <= (value[15] && !(view_index inside {4'h1, 4'h5})) ?
                16'(-value) : 16'(value);
        end
    end
endmodule // value_formatter
`default_nettype wire

// >>> pdm_sva.sv
`timescale 1ns/100ps
`default_nettype none
module pdm_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [5:0] display_code,
    input wire logic display_dash,
    input wire logic option_strobe,
    input wire logic [7:0] fan_high_voltage,
    input wire logic [7:0] fan_low_voltage,
    input wire logic [7:0] slave_addr,
    input wire logic [7:0] valve_delay,
    input wire logic [2:0] baud_select,
    input wire logic [1:0] parity_select
);
    default clocking @(posedge clk); endclocking
    // message ends
    sequence s_name_end;
        display_code == menu_pkg::disp_name ##1 display_code != menu_pkg::disp_name;
    endsequence
    sequence s_version_end;
        display_code == menu_pkg::disp_version ##1 display_code != menu_pkg::disp_version;
    endsequence
    // defaults after reset
    chk_reset_fan: assert property (
        !reset_n |=> fan_high_voltage == 8'h14 && fan_low_voltage == 8'h32)
        else $error("fan default");
    chk_reset_level_two: assert property (
        !reset_n |=> slave_addr == 8'h2c && valve_delay == 8'h28)
        else $error("level 2 default");
    chk_reset_serial: assert property (
        !reset_n |=> baud_select == 3'h4 && parity_select == 2'h1)
        else $error("serial default");
    chk_intro_name: assert property (
        !reset_n |=> display_code == menu_pkg::disp_name)
        else $error("name not first");
    // intro order
    chk_intro_version: assert property (
        disable iff (!reset_n) s_name_end |-> display_code == menu_pkg::disp_version)
        else $error("no version");
    chk_intro_ident: assert property (
        disable iff (!reset_n) s_version_end |-> display_code == menu_pkg::disp_ident)
        else $error("no ident");
    chk_dash_view: assert property (
        disable iff (!reset_n) display_dash |-> display_code inside {[6'h11:6'h1d]})
        else $error("stray dash");
    chk_strobe_pulse: assert property (
        disable iff (!reset_n) option_strobe |=> !option_strobe)
        else $error("long strobe");
endmodule // pdm_sva
`default_nettype wire

// >>> tech_button.sv
`timescale 1ns/100ps
`default_nettype none
module tech_button #(
    parameter int hold = 50
) (
    input wire logic clk,
    input wire logic [5:0] display_code,
    output logic menu_push_button
);
    initial menu_push_button = 1'b0;
    // close with one short bounce
    task automatic press();
        @(posedge clk);
        #1 menu_push_button = 1'b1;
        @(posedge clk);
        #1 menu_push_button = 1'b0;
        @(posedge clk);
        #1 menu_push_button = 1'b1;
    endtask
    // release well before hold
    task automatic tap();
        press();
        repeat (hold / 3) @(posedge clk);
        #1 menu_push_button = 1'b0;
        repeat (hold / 3) @(posedge clk);
    endtask
    // hold until the code shows
    task automatic hold_to(input logic [5:0] code, output bit ok);
        int n;
        ok = 1'b0;
        press();
        for (n = 0; n < 400 && !ok; n++) begin
            @(posedge clk);
            ok = (display_code === code);
        end
        #1 menu_push_button = 1'b0;
    endtask
endmodule // tech_button
`default_nettype wire

// >>> pushbutton_display_menu_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pushbutton_display_menu_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic btn;
    logic comp_on = 1'b0;
    logic [3:0] stat = 4'h0;
    logic [13:0] valid = 14'h0;
    logic [15:0] sp, dp, st, dt, it;
    logic [7:0] cap, v1, v2, fan_hi, fan_lo, addr, vdel;
    logic [5:0] code, sel;
    logic [15:0] value;
    logic neg, dash, strobe, comm, test_on, flash, req = 1'b0;
    logic [2:0] baud;
    logic [1:0] par;
    int fail_count = 0;
    int cmp_count = 0;
    int seed;
    int ev [14];
    bit ok;
    always #2.5 clk = ~clk;
    pushbutton_display_menu #(.view_timeout(200), .hold(50), .char_period(20),
        .intro_period(10), .debounce(3)) dut_u (.clk(clk), .reset_n(reset_n),
        .menu_push_button(btn), .startup_delay(stat[0]), .remote_off(stat[1]),
        .pressure_too_high(stat[2]), .timer_hold(stat[3]), .compressor_on(comp_on),
        .start_request(req), .view_valid(valid), .suction_pressure(sp),
        .discharge_pressure(dp), .suction_temp(st), .discharge_temp(dt), .deice_temp(it),
        .capacity(cap), .valve_one_opening(v1), .valve_two_opening(v2),
        .display_code(code), .display_value(value), .display_negative(neg),
        .display_dash(dash), .display_flash(flash), .option_selected(sel), .option_strobe(strobe),
        .test_active(test_on), .commissioning(comm), .fan_high_voltage(fan_hi),
        .fan_low_voltage(fan_lo), .slave_addr(addr), .valve_delay(vdel),
        .fan_fixed_speed(), .remote_thermostat(), .sat_temp_control(), .baud_select(baud),
        .parity_select(par), .compressor_model_req(), .valve_mode_req());
    tech_button #(.hold(50)) btn_u (.clk(clk), .display_code(code), .menu_push_button(btn));
    // compare, count, report
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // bounded waits
    task automatic wait_code(input logic [5:0] c, input bit pick = 0);
        for (int n = 0; n < 300 && (pick ? strobe !== 1'b1 : code !== c); n++) begin
            @(posedge clk);
            #1;
        end
        check(16'(pick ? sel : code), 16'(c));
        if (pick ? strobe !== 1'b1 : code !== c) stop_test();
    endtask
    // main sequence
    initial begin
        seed = 32'h6872adc0;
        repeat (4) @(posedge clk);
        #1 reset_n = 1'b1;
        check(16'(code), 16'h0001);
        check({fan_hi, fan_lo}, 16'h1432);
        check({addr, vdel}, 16'h2c28);
        check({test_on, comm, 9'h0, baud, par}, 16'h0011);
        wait_code(6'h02);
        wait_code(6'h03);
        check(value, menu_pkg::ident_code);
        wait_code(6'h05);
        for (int i = 0; i < 4; i++) begin
            stat = 4'h1 << i;
            wait_code(6'(32'h07080604 >> 8 * i));
        end
        stat = 4'h0;
        $display("test status done");
        sp = 16'($random(seed)) & 16'h0fff;
        dp = 16'($random(seed)) & 16'h0fff;
        st = 16'($random(seed) % 50);
        dt = 16'($random(seed) % 50);
        it = 16'($random(seed) % 50);
        cap = 8'($random(seed)) & 8'h3f;
        v1 = 8'($random(seed)) & 8'h3f;
        v2 = 8'($random(seed)) & 8'h3f;
        valid = 14'($random(seed)) | 14'h0c0a;
        ev = '{-1, sp, sp / 20 - 40, $signed(st), -1, dp, dp / 20 - 40, $signed(dt), -1,
            $signed(it), cap, v1, v2, 44};
        wait_code(6'h05);
        for (int i = 1; i < 15; i++) begin
            btn_u.tap();
            wait_code(i < 14 ? 6'h10 + 6'(i) : 6'h05);
            if (i < 14) begin
                check(16'(dash), 16'(!valid[i]));
                if (valid[i] && ev[i] != -1) begin
                    check(value, 16'(ev[i] < 0 ? -ev[i] : ev[i]));
                    check(16'(neg), 16'(ev[i] < 0));
                end
            end
        end
        btn_u.tap();
        wait_code(6'h11);
        repeat (150) @(posedge clk);
        #1 check(16'(code), 16'h0011);
        wait_code(6'h05);
        check(16'(flash), 16'h0001);
        $display("test viewing done");
        for (int i = 0; i < 2; i++) begin
            #1 {comp_on, req} = 2'b10 >> i;
            btn_u.hold_to(6'h20, ok);
            check(16'(ok), 16'h0000);
            repeat (20) @(posedge clk);
        end
        #1 {comp_on, req} = 2'b00;
        btn_u.hold_to(6'h21, ok);
        wait_code(6'h09, 1);
        repeat (2) @(posedge clk);
        check(16'(comm), 16'h0001);
        wait_code(6'h05);
        btn_u.hold_to(6'h24, ok);
        wait_code(6'h0c, 1);
        btn_u.tap();
        wait_code(6'h11, 1);
        repeat (2) @(posedge clk);
        check({addr, vdel}, 16'h2c29);
        $display("test menu done");
        stop_test();
    end
endmodule // pushbutton_display_menu_tb_top
bind pushbutton_display_menu pdm_sva chk_u (.clk(clk), .reset_n(reset_n),
    .display_code(display_code), .display_dash(display_dash), .option_strobe(option_strobe),
    .fan_high_voltage(fan_high_voltage), .fan_low_voltage(fan_low_voltage),
    .slave_addr(slave_addr), .valve_delay(valve_delay), .baud_select(baud_select),
    .parity_select(parity_select));
`default_nettype wire
